// file: core/fpl_pkg.sv
// Constants, types and timing counts for the fast parallel config loader.
// Assumes a 100 MHz system clock and a host-driven configuration clock.
// Function
// - Request low restarts configuration from user mode
// - Status held low through power-on delay
// - Load complete low until all data accepted
// - Configuration clock ignored once configuration completes
// - Data on low 8 or 16 bits, or on all 32
// - Load complete rises only after successful load
// - Init flag low once option bit loaded
// - Load complete and status low within 600 ns
// - Status low 268 to 1506 us
// - One data word latched per rising edge
// - Oscillator init: user mode 175-437 us later
// - User clock enabled after four clock periods
// - Initialization lasts minimum clock cycle count
package fpl_pkg;

  // ==========================================================
  // Clock and widths
  // ==========================================================
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned CNT_W = 18;
  localparam int unsigned LINK_CNT_W = 24;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned IMAGE_WORDS_DEF = 1024;

  // ==========================================================
  // Timing figures and derived cycle counts
  // ==========================================================
  // Request low to status and load complete low, longest time
  localparam int unsigned REQ_TO_LOW_MAX_NS = 600;
  localparam int unsigned REQ_TO_LOW_CYC = REQ_TO_LOW_MAX_NS / CLK_PERIOD_NS;
  // Host request pulse, least time
  localparam int unsigned REQ_LOW_MIN_US = 2;
  // Status low pulse window
  localparam int unsigned STATUS_LOW_MIN_US = 268;
  localparam int unsigned STATUS_LOW_MAX_US = 1506;
  localparam int unsigned STATUS_LOW_CYC =
    (STATUS_LOW_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned STATUS_MAX_CYC =
    (STATUS_LOW_MAX_US * 1000) / CLK_PERIOD_NS;
  // Power-on delay before status is released
  localparam int unsigned POR_DELAY_US = 268;
  localparam int unsigned POR_CYC =
    (POR_DELAY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Oscillator-clocked initialization window
  localparam int unsigned INIT_OSC_MIN_US = 175;
  localparam int unsigned INIT_OSC_MAX_US = 437;
  localparam int unsigned INIT_OSC_CYC =
    (INIT_OSC_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // User clock enable delay: four fastest-allowed link periods
  localparam int unsigned CFG_CLK_MIN_PERIOD_NS = 8;
  localparam int unsigned CU_PERIODS = 4;
  localparam int unsigned CU_CYC =
    (CU_PERIODS * CFG_CLK_MIN_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Least initialization cycles on the user clock
  localparam int unsigned USR_INIT_CYCLES = 8576;
  // Falling link edges required after load completes
  localparam logic [1:0] FALL_EDGES = 2'h2;

  // ==========================================================
  // Option word fields (first word of the image)
  // ==========================================================
  localparam int unsigned OPT_INIT_FLAG_BIT = 0;
  localparam int unsigned OPT_USER_CLK_BIT = 1;

  // ==========================================================
  // Enumerations
  // ==========================================================
  typedef enum logic [1:0] {
    BW_8 = 2'h0,
    BW_16 = 2'h1,
    BW_32 = 2'h2
  } fpl_width_t;

  typedef enum logic [4:0] {
    ST_POR = 5'h01,
    ST_CLEAR = 5'h02,
    ST_LOAD = 5'h04,
    ST_INIT = 5'h08,
    ST_USER = 5'h10
  } fpl_state_t;

  // ==========================================================
  // Carriers and state records
  // ==========================================================
  // Everything that enters the system clock domain from outside
  typedef struct packed {
    logic [1:0] width;
    logic [1:0] opt;
    logic opt_valid;
    logic link_go;
    logic link_err;
    logic link_done;
    logic user_clk;
    logic status_in;
    logic req_n;
  } fpl_sync_bits_t;

  typedef struct packed {
    fpl_state_t st;
    logic [CNT_W-1:0] cnt;
    fpl_width_t width;
    logic status_low;
    logic load_done;
    logic init_low;
    logic user_mode;
    logic link_clear;
    logic user_sel;
    logic ucl_run;
    logic ucl_prev;
  } fpl_core_t;

  typedef struct packed {
    logic [LINK_CNT_W-1:0] cnt;
    logic [7:0] sum;
    logic [DATA_W-1:0] word;
    logic valid;
    logic done;
    logic err;
    logic [1:0] opt;
    logic opt_valid;
  } fpl_link_t;

  // ==========================================================
  // Reset values
  // ==========================================================
  localparam fpl_core_t CORE_RST = '{
    st: ST_POR, cnt: '0, width: BW_8, status_low: 1'b1,
    load_done: 1'b0, init_low: 1'b0, user_mode: 1'b0,
    link_clear: 1'b1, user_sel: 1'b0, ucl_run: 1'b0,
    ucl_prev: 1'b0};
  localparam fpl_link_t LINK_RST = '0;
  localparam logic [1:0] FALLS_RST = 2'h0;

endpackage : fpl_pkg

// file: core/fpl_sync.sv
// Two-flop level synchroniser for a bundle of independent levels.
// Assumes each bit is a level or quasi-static; bursts need a handshake.
module fpl_sync #(
  parameter int unsigned WIDTH = 1
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_srst,
  // Asynchronous levels in, synchronised levels out
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);

  // ==========================================================
  // State
  // ==========================================================
  typedef struct packed {
    logic [WIDTH-1:0] meta; // First stage, read only by second
    logic [WIDTH-1:0] safe; // Second stage, the only output
  } fpl_sync_st_t;

  fpl_sync_st_t s_reg;
  fpl_sync_st_t s_next;

  // Next-state: plain shift
  always_comb
  begin
    s_next = s_reg;
    s_next.meta = i_async;
    s_next.safe = s_reg.meta;
  end

  // Registers
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      s_reg <= '0;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign o_sync = s_reg.safe;

endmodule : fpl_sync

// file: core/fpl_loader.sv
// Configuration loader: reset handshake, word capture on the config
// clock, post-load edges and initialization timing.
// Assumes the host follows the request, wait and clock sequence, and
// that the user init clock is slower than half of I_CLK.
module fpl_loader #(
  parameter int unsigned IMAGE_WORDS = fpl_pkg::IMAGE_WORDS_DEF,
  parameter int unsigned STATUS_CYC = fpl_pkg::STATUS_LOW_CYC,
  parameter int unsigned POR_CYC = fpl_pkg::POR_CYC,
  parameter int unsigned OSC_CYC = fpl_pkg::INIT_OSC_CYC,
  parameter int unsigned USR_CYC = fpl_pkg::USR_INIT_CYCLES
) (
  // System clock and reset
  input wire logic I_CLK,
  input wire logic I_SRST,
  // Configuration link from the host
  input wire logic I_CONFIG_CLOCK,
  input wire logic [fpl_pkg::DATA_W-1:0] I_CONFIG_DATA,
  input wire logic I_CONFIG_REQUEST_N,
  // Open-drain status pin
  input wire logic I_CFG_STATUS_N,
  output logic O_CFG_STATUS_N,
  output logic O_CFG_STATUS_OE_N,
  // Straps and user initialization clock
  input wire logic [1:0] I_BUS_WIDTH,
  input wire logic I_USER_INIT_CLOCK,
  // Progress outputs
  output logic O_LOAD_COMPLETE,
  output logic O_INIT_COMPLETE_FLAG,
  output logic O_USER_MODE,
  // Accepted configuration words, config clock domain
  output logic [fpl_pkg::DATA_W-1:0] O_CFG_WORD,
  output logic O_CFG_WORD_VALID
);

  // ==========================================================
  // Declarations
  // ==========================================================
  // System clock domain state
  fpl_pkg::fpl_core_t r_reg;
  fpl_pkg::fpl_core_t r_next;
  // Rising-edge link state
  fpl_pkg::fpl_link_t l_reg;
  fpl_pkg::fpl_link_t l_next;
  // Falling-edge counter after load
  logic [1:0] falls_reg;
  logic [1:0] falls_next;
  // Raw and synchronised crossing bundles
  fpl_pkg::fpl_sync_bits_t raw;
  fpl_pkg::fpl_sync_bits_t s;
  // Width-masked incoming word
  logic [fpl_pkg::DATA_W-1:0] din;
  // Link reports two falling edges seen
  logic go;
  // Local copies of the package counter widths, used in sized casts
  localparam int unsigned CNT_W = fpl_pkg::CNT_W;
  localparam int unsigned LINK_CNT_W = fpl_pkg::LINK_CNT_W;

  // ==========================================================
  // Crossing into the system clock
  // ==========================================================
  // Pins and link levels all pass two flops before use.
  // The option bits are written once and stay put until the link
  // is cleared, so sampling them as levels is safe.
  always_comb
  begin
    raw.req_n = I_CONFIG_REQUEST_N;
    raw.status_in = I_CFG_STATUS_N;
    raw.user_clk = I_USER_INIT_CLOCK;
    raw.link_done = l_reg.done;
    raw.link_err = l_reg.err;
    raw.link_go = go;
    raw.opt_valid = l_reg.opt_valid;
    raw.opt = l_reg.opt;
    raw.width = I_BUS_WIDTH;
  end

  fpl_sync #(
    .WIDTH($bits(fpl_pkg::fpl_sync_bits_t))
  ) u_sync (
    .i_clk(I_CLK),
    .i_srst(I_SRST),
    .i_async(raw),
    .o_sync(s)
  );

  // ==========================================================
  // System clock sequencer
  // ==========================================================
  // Power-on hold, request clear, load, initialization, user mode.
  always_comb
  begin
    r_next = r_reg;
    // Previous user clock level for edge detection
    r_next.ucl_prev = s.user_clk;
    case (r_reg.st)
      // Power-on delay: status and load complete held low
      fpl_pkg::ST_POR:
      begin
        r_next.status_low = 1'b1;
        r_next.load_done = 1'b0;
        if (r_reg.cnt == CNT_W'(POR_CYC - 1))
        begin
          r_next.st = fpl_pkg::ST_CLEAR;
          r_next.cnt = '0;
        end
        else
        begin
          r_next.cnt = r_reg.cnt + 1'b1;
        end
      end
      // Restart pending: status low until the pulse is long enough
      fpl_pkg::ST_CLEAR:
      begin
        r_next.status_low = 1'b1;
        r_next.link_clear = 1'b1;
        if (!s.req_n)
        begin
          // Host still holding request: timing starts at its rise
          r_next.cnt = '0;
        end
        else if (r_reg.cnt == CNT_W'(STATUS_CYC - 1))
        begin
          // Release status and latch the bus width for this load
          r_next.st = fpl_pkg::ST_LOAD;
          r_next.status_low = 1'b0;
          r_next.cnt = '0;
          r_next.width = fpl_pkg::fpl_width_t'(s.width);
        end
        else
        begin
          r_next.cnt = r_reg.cnt + 1'b1;
        end
      end
      // Loading: link armed only while the status pin reads high
      fpl_pkg::ST_LOAD:
      begin
        // An outside party holding status low delays the load
        r_next.link_clear = !s.status_in;
        if (s.link_err)
        begin
          // Bad image: drop status for a full clear time, then rearm the link
          r_next.st = fpl_pkg::ST_CLEAR;
          r_next.status_low = 1'b1;
          r_next.link_clear = 1'b1;
          r_next.cnt = '0;
        end
        else
        begin
          if (s.link_done)
          begin
            r_next.load_done = 1'b1;
          end
          if (s.opt_valid && s.opt[fpl_pkg::OPT_INIT_FLAG_BIT])
          begin
            r_next.init_low = 1'b1;
          end
          if (s.link_go)
          begin
            // Two falling edges seen: freeze the link and initialize
            r_next.st = fpl_pkg::ST_INIT;
            r_next.link_clear = 1'b1;
            r_next.cnt = '0;
            r_next.ucl_run = 1'b0;
            r_next.user_sel = s.opt[fpl_pkg::OPT_USER_CLK_BIT];
          end
        end
      end
      // Initialization on the oscillator or on the user clock
      fpl_pkg::ST_INIT:
      begin
        r_next.link_clear = 1'b1;
        if (!r_reg.user_sel)
        begin
          // Oscillator source: fixed time after the two falling edges
          if (r_reg.cnt == CNT_W'(OSC_CYC - 1))
          begin
            r_next.st = fpl_pkg::ST_USER;
          end
          else
          begin
            r_next.cnt = r_reg.cnt + 1'b1;
          end
        end
        else if (!r_reg.ucl_run)
        begin
          // User clock not yet enabled; its edges are ignored
          if (r_reg.cnt == CNT_W'(fpl_pkg::CU_CYC - 1))
          begin
            r_next.ucl_run = 1'b1;
            r_next.cnt = '0;
          end
          else
          begin
            r_next.cnt = r_reg.cnt + 1'b1;
          end
        end
        else if (s.user_clk && !r_reg.ucl_prev)
        begin
          // Count rising user clock edges up to the minimum
          if (r_reg.cnt == CNT_W'(USR_CYC - 1))
          begin
            r_next.st = fpl_pkg::ST_USER;
          end
          else
          begin
            r_next.cnt = r_reg.cnt + 1'b1;
          end
        end
        else
        begin
          r_next.cnt = r_reg.cnt;
        end
      end
      // User mode: all lines high, data pins belong to the user
      fpl_pkg::ST_USER:
      begin
        r_next.user_mode = 1'b1;
        r_next.init_low = 1'b0;
        r_next.link_clear = 1'b1;
      end
      // Illegal code: fall back to a clean power-on sequence
      default:
      begin
        r_next = fpl_pkg::CORE_RST;
      end
    endcase
    // A request from any state but the power-on hold starts a new cycle; the sync path
    // adds three cycles, far inside the allowed reaction time.
    // The synchroniser clears to zero, which reads as a request for
    // two cycles after reset; the power-on hold ignores it, since
    // status is held low there anyway and the clear state re-checks.
    if (!s.req_n && r_reg.st != fpl_pkg::ST_POR)
    begin
      r_next.st = fpl_pkg::ST_CLEAR;
      r_next.status_low = 1'b1;
      r_next.load_done = 1'b0;
      r_next.init_low = 1'b0;
      r_next.user_mode = 1'b0;
      r_next.link_clear = 1'b1;
      r_next.cnt = '0;
    end
  end

  // System clock registers
  always_ff @(posedge I_CLK)
  begin
    if (I_SRST)
    begin
      r_reg <= fpl_pkg::CORE_RST;
    end
    else
    begin
      r_reg <= r_next;
    end
  end

  // ==========================================================
  // Link clock: word capture
  // ==========================================================
  // Width masking; the bus width register is static during a load.
  always_comb
  begin
    case (r_reg.width)
      fpl_pkg::BW_8:
      begin
        din = {24'h0, I_CONFIG_DATA[7:0]};
      end
      fpl_pkg::BW_16:
      begin
        din = {16'h0, I_CONFIG_DATA[15:0]};
      end
      default:
      begin
        din = I_CONFIG_DATA;
      end
    endcase
  end

  // One word per rising edge. The first word carries options and
  // the last one holds a byte sum of all words before it; a
  // mismatch is reported instead of load completion.
  always_comb
  begin
    l_next = l_reg;
    l_next.valid = 1'b0;
    if (!l_reg.done && !l_reg.err)
    begin
      l_next.word = din;
      l_next.valid = 1'b1;
      l_next.cnt = l_reg.cnt + 1'b1;
      if (l_reg.cnt == '0)
      begin
        l_next.opt = din[1:0];
        l_next.opt_valid = 1'b1;
      end
      if (l_reg.cnt == LINK_CNT_W'(IMAGE_WORDS - 1))
      begin
        // Final word: the image is accepted only if the sum agrees
        l_next.done = (din[7:0] == l_reg.sum);
        l_next.err = (din[7:0] != l_reg.sum);
      end
      else
      begin
        l_next.sum = l_reg.sum + din[7:0];
      end
    end
  end

  // Reset of the link side comes from a system clock flop. It rises
  // asynchronously and falls only while the host may not yet clock,
  // so no link edge meets its release.
  always_ff @(posedge I_CONFIG_CLOCK or posedge r_reg.link_clear)
  begin
    if (r_reg.link_clear)
    begin
      l_reg <= fpl_pkg::LINK_RST;
    end
    else
    begin
      l_reg <= l_next;
    end
  end

  // ==========================================================
  // Link clock: falling edges after load
  // ==========================================================
  // Counted from the link's own done flag, which precedes the
  // visible load complete, so no host edge is missed.
  always_comb
  begin
    falls_next = falls_reg;
    if (l_reg.done && falls_reg != fpl_pkg::FALL_EDGES)
    begin
      falls_next = falls_reg + 1'b1;
    end
  end

  always_ff @(negedge I_CONFIG_CLOCK or posedge r_reg.link_clear)
  begin
    if (r_reg.link_clear)
    begin
      falls_reg <= fpl_pkg::FALLS_RST;
    end
    else
    begin
      falls_reg <= falls_next;
    end
  end

  assign go = (falls_reg == fpl_pkg::FALL_EDGES);

  // ==========================================================
  // Outputs
  // ==========================================================
  // Status is open drain: the line is only ever pulled low
  assign O_CFG_STATUS_N = 1'b0;
  assign O_CFG_STATUS_OE_N = !r_reg.status_low;
  // Load complete stays low until the whole image is in
  assign O_LOAD_COMPLETE = r_reg.load_done;
  // Init flag released except between loading an option word with bit 0 set and user mode or a new request
  assign O_INIT_COMPLETE_FLAG = !r_reg.init_low;
  assign O_USER_MODE = r_reg.user_mode;
  // Word stream straight from link flops
  assign O_CFG_WORD = l_reg.word;
  assign O_CFG_WORD_VALID = l_reg.valid;

endmodule : fpl_loader

// file: bench/fpl_loader_sva.sv
// Checker for the loader's pin sequencing in the system clock domain.
// Assumes it is bound to the loader and sees only its ports.
module fpl_loader_sva #(
  parameter int unsigned STATUS_CYC = 20,
  parameter int unsigned OSC_CYC = 30,
  parameter int unsigned USR_CYC = 16
) (
  // Clock and reset
  input wire logic I_CLK,
  input wire logic I_SRST,
  // Watched pins
  input wire logic I_CONFIG_REQUEST_N,
  input wire logic O_CFG_STATUS_OE_N,
  input wire logic O_LOAD_COMPLETE,
  input wire logic O_INIT_COMPLETE_FLAG,
  input wire logic O_USER_MODE
);
  // Shortest init of either source; a user clock edge spans >= 2 cycles
  localparam int unsigned MIN_INIT = (OSC_CYC < USR_CYC) ? OSC_CYC : USR_CYC;
  logic [15:0] low_cnt_reg; // Consecutive cycles with status pulled low
  logic [15:0] hi_cnt_reg; // Consecutive cycles with load complete high

  // ==========================================================
  // Helper counters
  // ==========================================================
  always_ff @(posedge I_CLK)
  begin
    if (I_SRST)
    begin
      low_cnt_reg <= 16'h0;
      hi_cnt_reg <= 16'h0;
    end
    else
    begin
      low_cnt_reg <= O_CFG_STATUS_OE_N ? 16'h0 : low_cnt_reg + 16'h1;
      hi_cnt_reg <= O_LOAD_COMPLETE ? hi_cnt_reg + 16'h1 : 16'h0;
    end
  end

  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_SRST);

  // ==========================================================
  // Assertions
  // ==========================================================
  req_low_a: assert property ($fell(I_CONFIG_REQUEST_N) |->
    ##[1:60] (!O_CFG_STATUS_OE_N && !O_LOAD_COMPLETE))
    else $error("status or load complete late after request");
  req_hold_a: assert property (!I_CONFIG_REQUEST_N [*5] |->
    !O_CFG_STATUS_OE_N) else $error("status released during request");
  status_rel_a: assert property ($rose(I_CONFIG_REQUEST_N) |->
    ##[1:100] O_CFG_STATUS_OE_N) else $error("status never released");
  status_min_a: assert property ($rose(O_CFG_STATUS_OE_N) |->
    32'(low_cnt_reg) >= STATUS_CYC) else $error("status low too short");
  lc_status_a: assert property (!O_CFG_STATUS_OE_N |->
    !O_LOAD_COMPLETE) else $error("load complete high while status low");
  um_lc_a: assert property (O_USER_MODE |-> O_LOAD_COMPLETE)
    else $error("user mode without load complete");
  flag_fall_a: assert property ($fell(O_INIT_COMPLETE_FLAG) |->
    !O_LOAD_COMPLETE && !O_USER_MODE) else $error("init flag fell late");
  flag_um_a: assert property (O_USER_MODE |-> O_INIT_COMPLETE_FLAG)
    else $error("init flag low in user mode");
  init_delay_a: assert property ($rose(O_LOAD_COMPLETE) |->
    !O_USER_MODE [*4]) else $error("user mode too soon after load");
  init_min_a: assert property ($rose(O_USER_MODE) |->
    32'(hi_cnt_reg) >= MIN_INIT) else $error("initialization too short");

  // Main scenarios reached
  lc_rise_c: cover property ($rose(O_LOAD_COMPLETE));
  um_rise_c: cover property ($rose(O_USER_MODE));
  flag_fall_c: cover property ($fell(O_INIT_COMPLETE_FLAG));
endmodule : fpl_loader_sva

// file: bench/fpl_host_model.sv
// Host model: drives request, link clock and data words.
// Assumes the status wire is read back through a pull-up.
module fpl_host_model #(
  parameter int unsigned N = 8
) (
  // Status wire as read back
  input wire logic i_status_n,
  // Link toward the device
  output logic o_cclk,
  output logic o_req_n,
  output logic [31:0] o_data
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [31:0] sent [0:N-1]; // Last image sent, for the bench to compare

  // Link clock stands low between frames, never floating
  initial
  begin
    o_cclk = 1'b0;
    o_req_n = 1'b1;
    o_data = 32'h0;
  end

  // Request pulse of the least legal width
  task automatic request;
    o_req_n = 1'b0;
    #2000;
    o_req_n = 1'b1;
  endtask : request

  // Watch status, then keep the required gap before clocking
  task automatic wait_ready(output bit ok);
    int n;
    for (n = 0; n < 2000 && i_status_n !== 1'b1; n++) #10;
    ok = (n < 2000);
    #2000;
  endtask : wait_ready

  // One 15 ns link period: rising edge latches, falling edge ends it
  task automatic edge_pair;
    #7.5 o_cclk = 1'b1;
    #7.5 o_cclk = 1'b0;
  endtask : edge_pair

  // Whole image, one word per rising edge; a bad checksum on request
  task automatic send_image(input logic [7:0] opt, input bit good);
    logic [7:0] sum;
    sum = 8'h0;
    for (int k = 0; k < N; k++)
    begin
      if (k == 0) sent[k] = {24'h5a3c96, opt};
      else if (k == N - 1) sent[k] = {24'h0f1e2d, sum ^ {7'h0, !good}};
      else sent[k] = {24'ha1b2c3 ^ 24'(k), 8'(k * 37)};
      if (k < N - 1) sum += sent[k][7:0];
      o_data = sent[k];
      edge_pair();
    end
    // Released bus must not look like the last word
    o_data = ~o_data;
  endtask : send_image

  // Two more edge pairs; the first of their falling edges starts initialization
  task automatic post_falls;
    repeat (2) edge_pair();
  endtask : post_falls
endmodule : fpl_host_model

// file: bench/fpl_loader_tb_top.sv
// Self-checking bench for the fast parallel loader.
// Assumes the host model and checker files are compiled first.
module fpl_loader_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int N = 8, SC = 20, PC = 10, OC = 30, UC = 16;
  logic I_CLK = 1'b0;
  logic I_SRST = 1'b1;
  logic uclk = 1'b0; // User init clock, kept running throughout
  logic [1:0] bw = 2'h0; // Bus width strap, 8 bit at start
  logic cclk, req_n, oe_n, st_o, lc, flag, um, valid;
  logic [31:0] data, word;
  logic [31:0] seen [$]; // Words the loader reported as accepted
  int error_cnt = 0;
  int total_checks = 0;
  // Open-drain status wire with pull-up
  wire status_n = (oe_n === 1'b0) ? st_o : 1'b1;

  always #5 I_CLK = ~I_CLK;
  always #20 uclk = ~uclk;

  fpl_host_model #(.N(N)) host (.i_status_n(status_n), .o_cclk(cclk),
    .o_req_n(req_n), .o_data(data));
  fpl_loader #(.IMAGE_WORDS(N), .STATUS_CYC(SC), .POR_CYC(PC),
    .OSC_CYC(OC), .USR_CYC(UC)) dut (.I_CLK(I_CLK), .I_SRST(I_SRST),
    .I_CONFIG_CLOCK(cclk), .I_CONFIG_DATA(data),
    .I_CONFIG_REQUEST_N(req_n), .I_CFG_STATUS_N(status_n),
    .O_CFG_STATUS_N(st_o), .O_CFG_STATUS_OE_N(oe_n), .I_BUS_WIDTH(bw),
    .I_USER_INIT_CLOCK(uclk), .O_LOAD_COMPLETE(lc),
    .O_INIT_COMPLETE_FLAG(flag), .O_USER_MODE(um), .O_CFG_WORD(word),
    .O_CFG_WORD_VALID(valid));

  // Collect accepted words just after each rising link edge
  always @(posedge cclk)
  begin
    #1;
    if (valid === 1'b1) seen.push_back(word);
  end

  task automatic chk(input logic [31:0] got, exp, input string what);
    total_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : test_done

  function automatic logic pick(input int sel);
    case (sel)
      0: return lc;
      1: return um;
      default: return oe_n;
    endcase
  endfunction : pick

  // Bounded wait for a pin level; running out ends the run
  task automatic wait_on(input int sel, input logic lvl, input int lim,
    output int n);
    for (n = 0; n < lim && pick(sel) !== lvl; n++) @(posedge I_CLK) #1;
    if (n == lim)
    begin
      error_cnt++;
      $display("unexpected at %0t: wait on pin %0d timed out", $time, sel);
      test_done();
    end
  endtask : wait_on

  task automatic t_power_up;
    int n;
    bit ok;
    chk(oe_n, 1'b0, "status at reset");
    chk(lc, 1'b0, "load complete at reset");
    chk({um, flag}, 2'h1, "mode and flag at reset");
    wait_on(2, 1'b1, 1000, n);
    // First sample lies one edge after reset release
    chk(n, PC + SC - 1, "power-up status low time");
    host.wait_ready(ok);
    chk(ok, 1'b1, "status seen high");
    $display("power-up test done");
  endtask : t_power_up

  // Request from user mode; strap changes before status release
  task automatic t_request(input logic [1:0] width);
    int n;
    bit ok;
    @(posedge I_CLK) bw <= width;
    fork
      host.request();
      begin
        wait_on(2, 1'b0, 60, n);
        chk(lc, 1'b0, "load complete after request");
        chk(um, 1'b0, "user mode after request");
      end
    join
    host.wait_ready(ok);
    chk(ok, 1'b1, "status released after request");
    $display("request test done");
  endtask : t_request

  // Load one image and judge words, completion and initialization
  task automatic t_load(input logic [7:0] opt, input bit good,
    input logic [31:0] mask);
    int n;
    bit ok;
    seen.delete();
    host.send_image(opt, good);
    chk(seen.size(), N, "accepted word count");
    foreach (seen[k]) chk(seen[k], host.sent[k] & mask, "word");
    if (!good)
    begin
      wait_on(2, 1'b0, 20, n);
      chk(lc, 1'b0, "load complete after bad image");
      host.wait_ready(ok);
      chk(ok, 1'b1, "link rearmed after bad image");
      $display("bad image test done");
      return;
    end
    wait_on(0, 1'b1, 20, n);
    chk(flag, !opt[0], "init flag during init");
    fork
      host.post_falls();
      wait_on(1, 1'b1, 2000, n);
    join
    chk(32'(n >= (opt[1] ? (UC - 1) * 4 : OC)), 32'h1, "init time");
    chk(flag, 1'b1, "init flag in user mode");
    seen.delete();
    host.post_falls();
    repeat (3) @(posedge I_CLK);
    chk(seen.size(), 0, "link edges after load");
    chk({lc, um}, 2'h3, "still in user mode");
    $display("load test done");
  endtask : t_load

  initial
  begin
    repeat (4) @(posedge I_CLK);
    I_SRST <= 1'b0;
    @(posedge I_CLK) #1;
    t_power_up();
    t_load(8'h01, 1'b1, 32'h000000ff);
    t_request(2'h1);
    t_load(8'h00, 1'b0, 32'h0000ffff);
    t_load(8'h02, 1'b1, 32'h0000ffff);
    t_request(2'h2);
    t_load(8'h03, 1'b1, 32'hffffffff);
    test_done();
  end
endmodule : fpl_loader_tb_top

bind fpl_loader fpl_loader_sva #(.STATUS_CYC(STATUS_CYC),
  .OSC_CYC(OSC_CYC), .USR_CYC(USR_CYC)) u_sva (.I_CLK(I_CLK),
  .I_SRST(I_SRST), .I_CONFIG_REQUEST_N(I_CONFIG_REQUEST_N),
  .O_CFG_STATUS_OE_N(O_CFG_STATUS_OE_N), .O_LOAD_COMPLETE(O_LOAD_COMPLETE),
  .O_INIT_COMPLETE_FLAG(O_INIT_COMPLETE_FLAG), .O_USER_MODE(O_USER_MODE));
